// File: rtl/art_timer.sv
// Auto-reload 16-bit up-counting timer with an AXI4-Lite register slave.
// Assumes one clock, an asynchronous active-low reset and a CPU that pulses irq_ack_i on service entry.
// Summary of operation
// RULE1 - Single 16-bit up counter, auto reload only.
// RULE2 - Prescale field bits 2:0 divide 1 to 128.
// RULE3 - Run bit 3 halts or advances counter.
// RULE4 - Roll-over from FFFF sets flag, reloads.
// RULE5 - Reload copies high and low bytes in.
// RULE6 - Flag with enable bit requests interrupt.
// RULE7 - Interrupt entry clears overflow flag automatically.
// RULE8 - Software may set or clear overflow flag.
// RULE9 - Software writes reload bytes only while halted.
// RULE10 - Overflow offered as serial baud clock source.
// RULE11 - Reload bytes are reset-zero read-write registers.
// RULE12 - Reset clears counter, prescaler, run, flag.
// RULE13 - Prescaler divides system clock, runs only running.
`timescale 1ns/1ns
module art_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [11:0] s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        irq_ack_i,
    output logic             irq_o,
    output logic             baud_tick_o,
    output logic             baud_sel_o
);

    art_pkg::art_ctrl_type ctrl_ff;
    logic [7:0]            reload_lo_ff;
    logic [7:0]            reload_hi_ff;
    logic [7:0]            irq_en_ff;
    logic [15:0]           count_ff;
    logic [15:0]           nxt_count;
    logic [6:0]            presc_ff;
    logic [7:0]            tick_by_code;
    logic                  tick;
    art_pkg::art_ctrl_type nxt_ctrl;
    logic                  wr_ctrl;
    logic                  wr_lo;
    logic                  wr_hi;
    logic                  wr_irq_en;
    logic                  overflow;
    logic [11:0]           awaddr_ff;
    logic                  aw_have_ff;
    logic [31:0]           wdata_ff;
    logic [3:0]            wstrb_ff;
    logic                  w_have_ff;
    logic                  wr_fire;
    logic                  wr_ok;
    logic [31:0]           rd_word;
    logic                  rd_ok;

    // Write address and data are latched separately, in either order.
    assign s_axi_awready_o = !aw_have_ff && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_have_ff && !s_axi_bvalid_o;
    assign wr_fire         = aw_have_ff && w_have_ff && !s_axi_bvalid_o;

    // Write decode: one strobe per writable register, raised only in the cycle the buffered write fires.
    always_comb begin
        wr_ok     = 1'b1;
        wr_ctrl   = 1'b0;
        wr_lo     = 1'b0;
        wr_hi     = 1'b0;
        wr_irq_en = 1'b0;
        case (awaddr_ff)
            art_pkg::CTRL_ADDR: begin
                wr_ctrl = wr_fire && wstrb_ff[0];
            end
            art_pkg::RELOAD_LO_ADDR: begin
                wr_lo = wr_fire && wstrb_ff[0];
            end
            art_pkg::RELOAD_HI_ADDR: begin
                wr_hi = wr_fire && wstrb_ff[0];
            end
            art_pkg::IRQ_EN_ADDR: begin
                wr_irq_en = wr_fire && wstrb_ff[0];
            end
            // The count is read-only; a write to it is acknowledged and dropped.
            art_pkg::STATUS_ADDR: begin
                wr_ok = 1'b1;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_ff <= 1'b0;
            awaddr_ff  <= 12'h000;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr_i;
        end else if (wr_fire) begin
            aw_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_have_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata_i;
            wstrb_ff  <= s_axi_wstrb_i;
        end else if (wr_fire) begin
            w_have_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= art_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_ok ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Prescaler: code n ticks when the low n divider bits are all ones, once every 2^n run cycles.
    assign tick_by_code[0] = 1'b1;
    for (genvar n = 1; n < 8; n++) begin : g_tick
        assign tick_by_code[n] = &presc_ff[n-1:0];
    end
    assign tick = tick_by_code[ctrl_ff.prescale_select]; // [RULE2]

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_ff <= art_pkg::PRESC_RST; // [RULE12]
        end else if (ctrl_ff.run_control_bit) begin
            presc_ff <= presc_ff + 7'h01; // [RULE13]
        end
    end

    assign overflow = ctrl_ff.run_control_bit && tick && (count_ff == art_pkg::COUNT_MAX); // [RULE4]

    always_comb begin
        nxt_count = count_ff;
        if (overflow) begin
            nxt_count = {reload_hi_ff, reload_lo_ff}; // [RULE5]
        end else if (ctrl_ff.run_control_bit && tick) begin
            nxt_count = count_ff + 16'h0001; // [RULE1] [RULE3]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_ff <= art_pkg::COUNT_RST; // [RULE12]
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Next control value: software write, then interrupt entry, then hardware overflow.
    // Taking the overflow last means an overflow in the same cycle as any clear still sets the flag.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = art_pkg::art_ctrl_type'(wdata_ff[7:0]); // [RULE8]
        end else if (irq_ack_i) begin
            nxt_ctrl.overflow_flag = 1'b0; // [RULE7]
        end
        if (overflow) begin
            nxt_ctrl.overflow_flag = 1'b1; // [RULE4]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= art_pkg::CTRL_RST; // [RULE12]
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // Writes while running are accepted as written; software must halt first.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reload_lo_ff <= art_pkg::RELOAD_RST;
        end else if (wr_lo) begin
            reload_lo_ff <= wdata_ff[7:0]; // [RULE11] [RULE9]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reload_hi_ff <= art_pkg::RELOAD_RST;
        end else if (wr_hi) begin
            reload_hi_ff <= wdata_ff[7:0]; // [RULE11]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_en_ff <= art_pkg::IRQ_EN_RST;
        end else if (wr_irq_en) begin
            irq_en_ff <= wdata_ff[7:0];
        end
    end

    // The request follows the flag one cycle later while the enable bit is set.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= ctrl_ff.overflow_flag && irq_en_ff[art_pkg::IRQ_EN_BIT]; // [RULE6]
        end
    end

    // One pulse per overflow; the serial ports may use it as their baud clock.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baud_tick_o <= 1'b0;
        end else begin
            baud_tick_o <= overflow; // [RULE10]
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baud_sel_o <= 1'b0;
        end else begin
            baud_sel_o <= ctrl_ff.baud_clock_select; // [RULE10]
        end
    end

    // Read decode: the word is captured with the address, so it stands while rvalid is high.
    // Unmapped addresses answer with an error and a zero word.
    always_comb begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr_i)
            art_pkg::CTRL_ADDR:      rd_word = {24'h000000, ctrl_ff};
            art_pkg::RELOAD_LO_ADDR: rd_word = {24'h000000, reload_lo_ff};
            art_pkg::RELOAD_HI_ADDR: rd_word = {24'h000000, reload_hi_ff};
            art_pkg::IRQ_EN_ADDR:    rd_word = {24'h000000, irq_en_ff};
            art_pkg::STATUS_ADDR:    rd_word = {16'h0000, count_ff};
            default:                 rd_ok   = 1'b0;
        endcase
    end

    // Only one read may be outstanding; a new address waits until the data is taken.
    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= art_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= rd_word;
            s_axi_rresp_o  <= rd_ok ? art_pkg::RESP_OKAY : art_pkg::RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

endmodule

// File: rtl/art_pkg.sv
// Package for the auto-reload timer: register map, field positions and reset values.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package art_pkg;

    // Printed offsets are not all multiples of four, so they are register indices.
    localparam logic [7:0]  CTRL_IDX        = 8'hC4;
    localparam logic [7:0]  RELOAD_LO_IDX   = 8'hC5;
    localparam logic [7:0]  RELOAD_HI_IDX   = 8'hC6;
    localparam logic [7:0]  IRQ_EN_IDX      = 8'hC7;
    localparam logic [7:0]  STATUS_IDX      = 8'hC8;
    localparam logic [11:0] CTRL_ADDR       = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] RELOAD_LO_ADDR  = {2'h0, RELOAD_LO_IDX, 2'h0};
    localparam logic [11:0] RELOAD_HI_ADDR  = {2'h0, RELOAD_HI_IDX, 2'h0};
    localparam logic [11:0] IRQ_EN_ADDR     = {2'h0, IRQ_EN_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR     = {2'h0, STATUS_IDX, 2'h0};

    localparam int          PS_LSB          = 0;
    localparam int          PS_MSB          = 2;
    localparam int          RUN_BIT         = 3;
    localparam int          OVF_BIT         = 4;
    localparam int          BAUD_SEL_BIT    = 5;
    localparam int          SMOD0_BIT       = 6;
    localparam int          SMOD_BIT        = 7;
    localparam int          IRQ_EN_BIT      = 1;

    localparam logic [7:0]  CTRL_RST        = 8'h00;
    localparam logic [7:0]  RELOAD_RST      = 8'h00;
    localparam logic [7:0]  IRQ_EN_RST      = 8'h00;
    localparam logic [15:0] COUNT_RST       = 16'h0000;
    localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
    localparam logic [6:0]  PRESC_RST       = 7'h00;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic       smod;
        logic       smod0;
        logic       baud_clock_select;
        logic       overflow_flag;
        logic       run_control_bit;
        logic [2:0] prescale_select;
    } art_ctrl_type;

endpackage

// File: dv/art_timer_monitor.sv
// Checker for the auto-reload timer, bound to the timer's own ports.
// Assumes a single clock and the asynchronous active-low reset.
`timescale 1ns/1ns
module art_timer_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        s_axi_bvalid_o,
    input wire logic        s_axi_bready_i,
    input wire logic        s_axi_arvalid_i,
    input wire logic        s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic        s_axi_rvalid_o,
    input wire logic        s_axi_rready_i,
    input wire logic        irq_ack_i,
    input wire logic        irq_o,
    input wire logic        baud_tick_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence ack_quiet_s;
        irq_ack_i ##1 !baud_tick_o [*2];
    endsequence
    a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("no read data");
    a_read_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read taken while busy");
    a_read_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o) else $error("rvalid stuck");
    a_write_done: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o) else $error("bvalid stuck");
    a_read_width: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper bits set");
    a_tick_single: assert property (baud_tick_o |=> !baud_tick_o) else $error("tick too long");
    a_ack_clears: assert property (ack_quiet_s |-> !irq_o) else $error("irq after ack");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !irq_o && !baud_tick_o)
        else $error("busy at reset");
endmodule
bind art_timer art_timer_monitor mon_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .irq_ack_i(irq_ack_i),
    .irq_o(irq_o), .baud_tick_o(baud_tick_o)
);

// File: dv/art_timer_tb.sv
// Self-checking bench for the auto-reload timer over its register bus.
// Assumes art_timer with its bound checker; the bench drives every input.
`timescale 1ns/1ns
module art_timer_tb;
    localparam logic [11:0] CA = art_pkg::CTRL_ADDR, LA = art_pkg::RELOAD_LO_ADDR, HA = art_pkg::RELOAD_HI_ADDR;
    localparam logic [11:0] IA = art_pkg::IRQ_EN_ADDR, SA = art_pkg::STATUS_ADDR;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic        ack = 1'b0, awr, wrd, bv, arr, rvd, irq, tick, bsel;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0]  bresp, rresp, rr;
    logic [15:0] rl;
    int          num_errors = 0, n_compared = 0, seed = 25, per, k;
    art_timer dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(addr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(addr),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvd), .s_axi_rready_i(rry), .irq_ack_i(ack), .irq_o(irq), .baud_tick_o(tick),
        .baud_sel_o(bsel)
    );
    initial forever #10 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic hang;
        num_errors++;
        $display("BAD wait expected done seen timeout");
        finish_test();
    endtask
    // One write or one read; every channel holds until its own ready.
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d = 8'h00);
        int   i;
        logic ta, tw, tr, done;
        @(posedge clk_i);
        addr <= a;
        wdata <= {24'h0, d};
        {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
        for (i = 0; i < 50; i++) begin
            // Handshakes are judged on values settled before the coming edge.
            @(negedge clk_i);
            ta   = awv && awr;
            tw   = wv && wrd;
            tr   = arv && arr;
            done = (bv && bry) || (rvd && rry);
            rv   = rdata;
            rr   = w ? bresp : rresp;
            @(posedge clk_i);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tr) arv <= 1'b0;
            if (done) break;
        end
        {bry, rry} <= 2'b00;
        if (i == 50) hang();
    endtask
    task automatic wait_tick(output int n);
        for (n = 1; n < 70000; n++) begin
            @(negedge clk_i);
            if (tick) return;
        end
        hang();
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a);
        chk("read", e, rv);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rc(CA, 32'h0);
        rc(LA, 32'h0);
        rc(SA, 32'h0);
        rc(12'h400, 32'h0);
        chk("resp", 32'(art_pkg::RESP_SLVERR), 32'(rr));
        bus(1'b1, 12'h400, 8'h00);
        chk("bresp", 32'(art_pkg::RESP_SLVERR), 32'(rr));
        for (k = 0; k < 8; k++) begin
            rl = 16'hFFE0 | 16'($random(seed) & 15);
            bus(1'b1, CA, 8'h00);
            bus(1'b1, LA, rl[7:0]);
            bus(1'b1, HA, rl[15:8]);
            rc(HA, 32'(rl[15:8]));
            bus(1'b1, CA, 8'h08 | 8'(k));
            wait_tick(per);
            wait_tick(per);
            chk("period", (32'h10000 - 32'(rl)) << k, 32'(per));
            rc(CA, 32'h18 | 32'(k));
        end
        bus(1'b1, CA, 8'h00);
        bus(1'b1, IA, 8'h02);
        bus(1'b1, CA, 8'h10);
        @(negedge clk_i);
        chk("irq", 32'h1, 32'(irq));
        @(posedge clk_i);
        ack <= 1'b1;
        @(posedge clk_i);
        ack <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk("irq", 32'h0, 32'(irq));
        bus(1'b1, CA, 8'hE0);
        rc(CA, 32'hE0);
        chk("bsel", 32'h1, 32'(bsel));
        finish_test();
    end
endmodule
